// file: common/sps_defs.svh
// Constants for the servo position status block: reset values, ranges, codes and timing
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// ====================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define SPS_OFF_MODE        8'h00
`define SPS_OFF_FOLLOW_THR  8'h04
`define SPS_OFF_MARGIN      8'h08
`define SPS_OFF_DWELL       8'h0C
`define SPS_OFF_JERK        8'h10
`define SPS_OFF_LOWPASS     8'h14
`define SPS_OFF_OUTCFG      8'h18
`define SPS_OFF_CMD_POS     8'h1C
`define SPS_OFF_ACT_POS     8'h20
`define SPS_OFF_CTRL        8'h24
`define SPS_OFF_STATUS      8'h28
`define SPS_OFF_ALARM       8'h2C
`define SPS_OFF_FILT_OUT    8'h30

// ====================================================================
// Reset values
`define SPS_RST_MODE        8'h15
`define SPS_RST_FOLLOW_THR  32'h0000_2710
`define SPS_RST_MARGIN      16'h0028
`define SPS_RST_DWELL       16'h000A
`define SPS_RST_JERK        8'h0A
`define SPS_RST_LOWPASS     16'h000A

// ====================================================================
// Ranges and codes
`define SPS_MAX_MARGIN      16'h7D00
`define SPS_MAX_DWELL       16'h7D00
`define SPS_MAX_JERK        8'hFA
`define SPS_MAX_LOWPASS     16'h2710
`define SPS_MODE_POSITION   8'h15

// ====================================================================
// Field positions of the control word
`define SPS_CTRL_ENABLE     0
`define SPS_CTRL_RUN        1
`define SPS_CTRL_POS_LIM    2
`define SPS_CTRL_NEG_LIM    3

// Field positions of the output config word (per output: 2-bit select, 1 polarity)
`define SPS_OCFG_SEL_LSB    0
`define SPS_OCFG_POL        2
`define SPS_OCFG_STRIDE     4

// Alarm bits
`define SPS_ALM_UNDERVOLT   0
`define SPS_ALM_LOWVOLT     1
`define SPS_ALM_FOLLOW      2

// ====================================================================
// Timing: 1 ms tick at 125 MHz
`define SPS_CLK_MHZ         125
`define SPS_MS_NS           1000000
`define SPS_CLK_NS          8
`define SPS_MS_CYCLES       (`SPS_MS_NS / `SPS_CLK_NS)

`endif

// file: common/sps_pkg.sv
// Types for the servo position status block
package sps_pkg;
  // Status flag selector for a digital output
  typedef enum logic [1:0] {
    SPS_SEL_FOLLOW = 2'h0,
    SPS_SEL_INPOS  = 2'h1,
    SPS_SEL_POSLIM = 2'h2,
    SPS_SEL_NEGLIM = 2'h3
  } sps_sel_e;

  // Drive enable sequence (Gray along the usual path)
  typedef enum logic [1:0] {
    SPS_ST_OFF     = 2'h0,
    SPS_ST_ON      = 2'h1,
    SPS_ST_ALARM   = 2'h3
  } sps_state_e;
endpackage : sps_pkg

// file: hw/sps_status.sv
// Position loop status outputs, limits, in-position, command smoothing and power alarms
`timescale 1ns/1ps
`include "sps_defs.svh"

// Contract
// - Flag following error above threshold while running
// - Normal polarity: closed while error exceeds
// - Inverted polarity: open while error exceeds
// - Assert positive limit flag on positive limit
// - Assert negative limit flag on negative limit
// - Block motion into active limit only
// - Limit outputs support both polarities
// - In-position after margin held for dwell
// - Margin 0..32000 pulses, default 40
// - Dwell 0..32000 ms, default 10
// - In-position output may be inverted
// - Mode code 21 selects position control
// - Jerk smoothing 0..250 ms, default 10
// - Low-pass filter 0..10000 ms
// - Zero time constant bypasses filter
// - Filters act in every control mode
// - Servo ready low without main power
// - Enable without main power raises alarm
// - Power loss while enabled reports alarms
module sps_status #(
  parameter int NUM_OUT = 3,                // Number of digital outputs
  parameter int MS_CYCLES = `SPS_MS_CYCLES  // Clock cycles per millisecond
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Power and motion pins
  input wire logic main_pwr_i,
  input wire logic motor_run_i,
  // Status and control outputs
  output logic [NUM_OUT-1:0] dout_o,
  output logic servo_ready_o,
  output logic motor_en_o,
  output logic motion_pos_ok_o,
  output logic motion_neg_ok_o,
  output logic [31:0] filt_cmd_o
);

  // ==================================================================
  // Pin synchronisers
  logic [1:0] pwr_sync_r;   // Main power pin, two stages
  logic [1:0] run_sync_r;   // Motor running pin, two stages
  wire pwr_ok = pwr_sync_r[1];
  wire run_ok = run_sync_r[1];

  // Two flops per pin before use
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_sync_r <= 2'h0;
      run_sync_r <= 2'h0;
    end else begin
      pwr_sync_r <= {pwr_sync_r[0], main_pwr_i};
      run_sync_r <= {run_sync_r[0], motor_run_i};
    end
  end

  // ==================================================================
  // Configuration registers
  logic [7:0] control_mode_select_r;      // Control mode code
  logic [31:0] follow_error_threshold_r;  // Following error limit, pulses
  logic [15:0] positioning_margin_r;      // In-position band, pulses
  logic [15:0] in_position_dwell_time_r;  // Dwell, ms
  logic [7:0] jerk_time_constant_r;       // Jerk smoothing, ms
  logic [15:0] lowpass_time_constant_r;   // Low-pass, ms
  logic [4*NUM_OUT-1:0] outcfg_r;         // Per output select and polarity
  logic signed [31:0] cmd_pos_r;          // Raw commanded position
  logic signed [31:0] act_pos_r;          // Actual position
  logic [3:0] ctrl_r;                     // Enable, run cmd, limit hits

  // Write decode
  wire wr_mode = wr_i && (addr_i == `SPS_OFF_MODE);
  wire wr_thr = wr_i && (addr_i == `SPS_OFF_FOLLOW_THR);
  wire wr_margin = wr_i && (addr_i == `SPS_OFF_MARGIN);
  wire wr_dwell = wr_i && (addr_i == `SPS_OFF_DWELL);
  wire wr_jerk = wr_i && (addr_i == `SPS_OFF_JERK);
  wire wr_lp = wr_i && (addr_i == `SPS_OFF_LOWPASS);
  wire wr_ocfg = wr_i && (addr_i == `SPS_OFF_OUTCFG);
  wire wr_cmd = wr_i && (addr_i == `SPS_OFF_CMD_POS);
  wire wr_act = wr_i && (addr_i == `SPS_OFF_ACT_POS);
  wire wr_ctrl = wr_i && (addr_i == `SPS_OFF_CTRL);
  wire wr_alarm = wr_i && (addr_i == `SPS_OFF_ALARM);

  // Clamp writes to the legal ranges
  wire [15:0] margin_in = (wdata_i[15:0] > `SPS_MAX_MARGIN) ? `SPS_MAX_MARGIN : wdata_i[15:0];
  wire [15:0] dwell_in = (wdata_i[15:0] > `SPS_MAX_DWELL) ? `SPS_MAX_DWELL : wdata_i[15:0];
  wire [7:0] jerk_in = (wdata_i[7:0] > `SPS_MAX_JERK) ? `SPS_MAX_JERK : wdata_i[7:0];
  wire [15:0] lp_in = (wdata_i[15:0] > `SPS_MAX_LOWPASS) ? `SPS_MAX_LOWPASS : wdata_i[15:0];

  // Register writes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_mode_select_r <= `SPS_RST_MODE;
      follow_error_threshold_r <= `SPS_RST_FOLLOW_THR;
      positioning_margin_r <= `SPS_RST_MARGIN;
      in_position_dwell_time_r <= `SPS_RST_DWELL;
      jerk_time_constant_r <= `SPS_RST_JERK;
      lowpass_time_constant_r <= `SPS_RST_LOWPASS;
      outcfg_r <= '0;
      cmd_pos_r <= 32'sh0;
      act_pos_r <= 32'sh0;
      ctrl_r <= 4'h0;
    end else begin
      if (wr_mode) control_mode_select_r <= wdata_i[7:0];
      if (wr_thr) follow_error_threshold_r <= wdata_i;
      if (wr_margin) positioning_margin_r <= margin_in;
      if (wr_dwell) in_position_dwell_time_r <= dwell_in;
      if (wr_jerk) jerk_time_constant_r <= jerk_in;
      if (wr_lp) lowpass_time_constant_r <= lp_in;
      if (wr_ocfg) outcfg_r <= wdata_i[4*NUM_OUT-1:0];
      if (wr_cmd) cmd_pos_r <= wdata_i;
      if (wr_act) act_pos_r <= wdata_i;
      if (wr_ctrl) ctrl_r <= wdata_i[3:0];
    end
  end

  // ==================================================================
  // Millisecond tick enable
  logic [31:0] ms_cnt_r;
  wire ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));

  // Free running divider
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) ms_cnt_r <= 32'h0;
    else ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
  end

  // ==================================================================
  // Command smoothing: first-order jerk stage then first-order low-pass
  logic signed [31:0] jerk_out_r;  // Jerk stage output
  logic signed [31:0] lp_out_r;    // Low-pass stage output
  // Jerk stage moves 1/T of the remaining step each ms
  wire signed [31:0] jerk_diff = cmd_pos_r - jerk_out_r;
  wire signed [31:0] jerk_step = jerk_diff / $signed({24'h0, jerk_time_constant_r});
  wire signed [31:0] jerk_in_v = (jerk_time_constant_r == 8'h0) ? cmd_pos_r : jerk_out_r;
  wire signed [31:0] lp_diff = jerk_in_v - lp_out_r;
  wire signed [31:0] lp_step = lp_diff / $signed({16'h0, lowpass_time_constant_r});
  wire signed [31:0] filt_v = (lowpass_time_constant_r == 16'h0) ? jerk_in_v : lp_out_r;

  // Filters update every ms regardless of control mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jerk_out_r <= 32'sh0;
      lp_out_r <= 32'sh0;
    end else if (ms_tick) begin
      // Step, or snap when the remainder is below one unit of progress
      if (jerk_time_constant_r == 8'h0) jerk_out_r <= cmd_pos_r;
      else if (jerk_step == 32'sh0) jerk_out_r <= cmd_pos_r;
      else jerk_out_r <= jerk_out_r + jerk_step;
      if (lowpass_time_constant_r == 16'h0) lp_out_r <= jerk_in_v;
      else if (lp_step == 32'sh0) lp_out_r <= jerk_in_v;
      else lp_out_r <= lp_out_r + lp_step;
    end
  end

  // ==================================================================
  // Error comparisons, evaluated every cycle
  wire signed [31:0] pos_err = filt_v - act_pos_r;
  wire [31:0] abs_err = pos_err[31] ? 32'(-pos_err) : pos_err;
  wire pos_mode = (control_mode_select_r == `SPS_MODE_POSITION);
  wire running = run_ok || ctrl_r[`SPS_CTRL_RUN];
  wire follow_err = running && (abs_err > follow_error_threshold_r);
  wire in_band = pos_mode && (abs_err < {16'h0, positioning_margin_r});

  // ==================================================================
  // In-position dwell timer
  logic [15:0] dwell_cnt_r;  // Elapsed ms inside the band
  logic in_pos_r;            // In-position flag
  wire dwell_done = (dwell_cnt_r >= in_position_dwell_time_r);

  // Restart whenever the error leaves the band
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dwell_cnt_r <= 16'h0;
      in_pos_r <= 1'b0;
    end else if (!in_band) begin
      dwell_cnt_r <= 16'h0;
      in_pos_r <= 1'b0;
    end else begin
      if (ms_tick && !dwell_done) dwell_cnt_r <= dwell_cnt_r + 16'h1;
      in_pos_r <= dwell_done;
    end
  end

  // ==================================================================
  // Limits and enable sequence
  wire pos_lim = ctrl_r[`SPS_CTRL_POS_LIM];
  wire neg_lim = ctrl_r[`SPS_CTRL_NEG_LIM];
  sps_pkg::sps_state_e state_r;
  sps_pkg::sps_state_e state_nxt;
  logic [2:0] alarm_r;  // Under-voltage warning, low-voltage fault, following error
  wire en_req = ctrl_r[`SPS_CTRL_ENABLE];

  // Next state of the drive enable
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sps_pkg::SPS_ST_OFF: begin
        if (en_req && !pwr_ok) state_nxt = sps_pkg::SPS_ST_ALARM;
        else if (en_req) state_nxt = sps_pkg::SPS_ST_ON;
      end
      sps_pkg::SPS_ST_ON: begin
        if (!pwr_ok) state_nxt = sps_pkg::SPS_ST_ALARM;
        else if (!en_req) state_nxt = sps_pkg::SPS_ST_OFF;
      end
      sps_pkg::SPS_ST_ALARM: begin
        if (!en_req && alarm_r == 3'h0) state_nxt = sps_pkg::SPS_ST_OFF;
      end
      default: state_nxt = sps_pkg::SPS_ST_OFF;
    endcase
  end

  // Alarm set terms; set wins over a software clear
  wire [2:0] alarm_set = {
    (state_r == sps_pkg::SPS_ST_ON) && !pwr_ok && follow_err,
    en_req && !pwr_ok,
    (state_r == sps_pkg::SPS_ST_ON) && !pwr_ok
  };
  wire [2:0] alarm_clr = wr_alarm ? wdata_i[2:0] : 3'h0;

  // State and sticky alarms
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= sps_pkg::SPS_ST_OFF;
      alarm_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      alarm_r <= (alarm_r & ~alarm_clr) | alarm_set;
    end
  end

  // ==================================================================
  // Output stage: pick a flag per output, apply polarity there only
  wire [3:0] flags = {neg_lim, pos_lim, in_pos_r, follow_err};
  logic [NUM_OUT-1:0] dout_r;

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    wire [1:0] sel = outcfg_r[g*`SPS_OCFG_STRIDE +: 2];
    wire pol = outcfg_r[g*`SPS_OCFG_STRIDE + `SPS_OCFG_POL];
    // Closed (1) when flag active, inverted when polarity set
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) dout_r[g] <= 1'b0;
      else dout_r[g] <= flags[sel] ^ pol;
    end
  end

  // ==================================================================
  // Registered outputs and read port
  wire [31:0] status_w = {26'h0, state_r, in_pos_r, neg_lim, pos_lim, follow_err};
  wire [31:0] rd_mux =
    (addr_i == `SPS_OFF_MODE) ? {24'h0, control_mode_select_r} :
    (addr_i == `SPS_OFF_FOLLOW_THR) ? follow_error_threshold_r :
    (addr_i == `SPS_OFF_MARGIN) ? {16'h0, positioning_margin_r} :
    (addr_i == `SPS_OFF_DWELL) ? {16'h0, in_position_dwell_time_r} :
    (addr_i == `SPS_OFF_JERK) ? {24'h0, jerk_time_constant_r} :
    (addr_i == `SPS_OFF_LOWPASS) ? {16'h0, lowpass_time_constant_r} :
    (addr_i == `SPS_OFF_OUTCFG) ? 32'(outcfg_r) :
    (addr_i == `SPS_OFF_CMD_POS) ? cmd_pos_r :
    (addr_i == `SPS_OFF_ACT_POS) ? act_pos_r :
    (addr_i == `SPS_OFF_CTRL) ? {28'h0, ctrl_r} :
    (addr_i == `SPS_OFF_STATUS) ? status_w :
    (addr_i == `SPS_OFF_ALARM) ? {29'h0, alarm_r} :
    (addr_i == `SPS_OFF_FILT_OUT) ? filt_v : 32'h0;

  // Output flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0;
      servo_ready_o <= 1'b0;
      motor_en_o <= 1'b0;
      motion_pos_ok_o <= 1'b0;
      motion_neg_ok_o <= 1'b0;
      filt_cmd_o <= 32'h0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0;
      servo_ready_o <= pwr_ok && (alarm_r == 3'h0);
      motor_en_o <= (state_r == sps_pkg::SPS_ST_ON) && pwr_ok;
      motion_pos_ok_o <= (state_r == sps_pkg::SPS_ST_ON) && !pos_lim;
      motion_neg_ok_o <= (state_r == sps_pkg::SPS_ST_ON) && !neg_lim;
      filt_cmd_o <= filt_v;
    end
  end

  assign dout_o = dout_r;

endmodule : sps_status

// file: dv/sps_status_chk_sva.sv
// Port checker of the servo position status block
`timescale 1ns/1ps
`include "sps_defs.svh"
module sps_status_chk (
  // Clock, reset and register port
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Power and status pins
  input wire logic main_pwr_i,
  input wire logic servo_ready_o,
  input wire logic motor_en_o,
  input wire logic motion_pos_ok_o,
  input wire logic motion_neg_ok_o
);
  // ====================================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Clamped fields never read above their ceiling
  a_margin_ceil: assert property (rd_i && addr_i == `SPS_OFF_MARGIN |=> rdata_o <= 32'h0000_7D00)
    else $error("margin read above ceiling");
  a_dwell_ceil: assert property (rd_i && addr_i == `SPS_OFF_DWELL |=> rdata_o <= 32'h0000_7D00)
    else $error("dwell read above ceiling");
  a_jerk_ceil: assert property (rd_i && addr_i == `SPS_OFF_JERK |=> rdata_o <= 32'h0000_00FA)
    else $error("jerk read above ceiling");
  a_lowpass_ceil: assert property (rd_i && addr_i == `SPS_OFF_LOWPASS |=> rdata_o <= 32'h0000_2710)
    else $error("lowpass read above ceiling");
  // No ready and no drive once power has been gone a while
  a_ready_nopwr: assert property (!main_pwr_i [*5] |-> !servo_ready_o)
    else $error("servo ready without main power");
  a_enable_nopwr: assert property (!main_pwr_i [*5] |-> !motor_en_o)
    else $error("drive enabled without main power");
  // Limit hits block motion in their direction
  a_pos_block: assert property (wr_i && addr_i == `SPS_OFF_CTRL && wdata_i[2] |-> ##2 !motion_pos_ok_o)
    else $error("positive motion allowed at limit");
  a_neg_block: assert property (wr_i && addr_i == `SPS_OFF_CTRL && wdata_i[3] |-> ##2 !motion_neg_ok_o)
    else $error("negative motion allowed at limit");
  // Main scenarios reached
  c_lowvolt: cover property (rd_i && addr_i == `SPS_OFF_ALARM ##1 rdata_o[1]);
  c_poslim: cover property (!motion_pos_ok_o && motion_neg_ok_o);
  c_pwr_loss: cover property (motor_en_o ##1 !main_pwr_i);
endmodule : sps_status_chk

// file: dv/sps_host_model.sv
// Host controller model sampling the digital outputs
`timescale 1ns/1ps
module sps_host_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Drive pins
  input wire logic [2:0] dout_i,
  input wire logic servo_ready_i,
  // Host view
  output logic [2:0] seen_o,
  output logic ready_seen_o
);
  // ====================================================================
  // Input sampler, one stage as a controller input adds
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_o <= 3'h0;
      ready_seen_o <= 1'h0;
    end else begin
      seen_o <= dout_i;
      ready_seen_o <= servo_ready_i; // Level only, a lingering ready is tolerated
    end
  end
endmodule : sps_host_model

// file: dv/sps_status_test.sv
// Self-checking bench of the servo position status block
`timescale 1ns/1ps
`include "sps_defs.svh"
module sps_status_test;
  // ====================================================================
  // Signals
  localparam int MS = 10; // Shortened millisecond
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic main_pwr_i = 1'h1;
  logic motor_run_i = 1'h0;
  logic [31:0] rdata_o, filt_cmd_o, rv, thr;
  logic [2:0] dout_o, seen;
  logic servo_ready_o, motor_en_o, motion_pos_ok_o, motion_neg_ok_o, rdy_seen;
  logic [31:0] seed_r = 32'h0000_DAA1;
  logic [7:0] rst_a [6] = '{`SPS_OFF_MODE, `SPS_OFF_FOLLOW_THR, `SPS_OFF_MARGIN, `SPS_OFF_DWELL, `SPS_OFF_JERK,
    `SPS_OFF_LOWPASS};
  logic [31:0] rst_v [6] = '{32'h15, 32'h2710, 32'h28, 32'hA, 32'hA, 32'hA};
  logic [7:0] cl_a [4] = '{`SPS_OFF_MARGIN, `SPS_OFF_DWELL, `SPS_OFF_JERK, `SPS_OFF_LOWPASS};
  logic [31:0] cl_m [4] = '{32'h7D00, 32'h7D00, 32'hFA, 32'h2710};
  int fail_count = 0;
  int n_tests = 0;
  int k;
  always #4 mclk_i = ~mclk_i;
  // ====================================================================
  // Design, host and checker
  sps_status #(.NUM_OUT(3), .MS_CYCLES(MS)) i_sps_status (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_pwr_i(main_pwr_i),
    .motor_run_i(motor_run_i), .dout_o(dout_o), .servo_ready_o(servo_ready_o), .motor_en_o(motor_en_o),
    .motion_pos_ok_o(motion_pos_ok_o), .motion_neg_ok_o(motion_neg_ok_o), .filt_cmd_o(filt_cmd_o));
  sps_host_model i_sps_host_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .dout_i(dout_o),
    .servo_ready_i(servo_ready_o), .seen_o(seen), .ready_seen_o(rdy_seen));
  // ====================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    #1 rv = rdata_o;
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_cyc
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk32
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  // ====================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i]);
      chk32(rv, rst_v[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(cl_a[i], cl_m[i] + 32'h1);
      rd_reg(cl_a[i]);
      chk32(rv, cl_m[i]);
      seed_r = lfsr(seed_r);
      wr_reg(cl_a[i], seed_r % (cl_m[i] + 32'h1));
      rd_reg(cl_a[i]);
      chk32(rv, seed_r % (cl_m[i] + 32'h1));
    end
    wr_reg(8'h40, 32'hFFFF);
    rd_reg(8'h40);
    chk32(rv, 32'h0);
    $display("Test registers done");
    // Each filter alone smooths a step, in velocity mode
    wr_reg(`SPS_OFF_MODE, 32'h0F);
    for (int f = 0; f < 2; f++) begin
      wr_reg(`SPS_OFF_JERK, f ? 32'h0 : 32'h5);
      wr_reg(`SPS_OFF_LOWPASS, f ? 32'h5 : 32'h0);
      wr_reg(`SPS_OFF_CMD_POS, f ? 32'h0 : 32'h3E8);
      for (k = 0; k < 800 && filt_cmd_o !== (f ? 32'h0 : 32'h3E8); k++) wait_cyc(1);
      chk32(k > 2 * MS && k < 800, 32'h1);
    end
    wr_reg(`SPS_OFF_LOWPASS, 32'h0);
    wr_reg(`SPS_OFF_CMD_POS, 32'h7D0);
    wait_cyc(3);
    chk32(filt_cmd_o, 32'h7D0);
    wr_reg(`SPS_OFF_CMD_POS, 32'h0);
    wr_reg(`SPS_OFF_MODE, 32'h15);
    $display("Test filters done");
    // Following error at the threshold and one above
    @(posedge mclk_i);
    motor_run_i <= 1'h1;
    seed_r = lfsr(seed_r);
    thr = (seed_r & 32'hFFF) + 32'h64;
    wr_reg(`SPS_OFF_FOLLOW_THR, thr);
    wr_reg(`SPS_OFF_OUTCFG, 32'h250);
    wr_reg(`SPS_OFF_ACT_POS, thr);
    wait_cyc(4);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[0], 32'h0);
    wr_reg(`SPS_OFF_ACT_POS, thr + 32'h1);
    wait_cyc(4);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[0], 32'h1);
    chk32(seen[0], 32'h1);
    wr_reg(`SPS_OFF_OUTCFG, 32'h254);
    wait_cyc(4);
    chk32(seen[0], 32'h0);
    // Stopped motor drops the flag, run bit of the control word raises it again
    @(posedge mclk_i);
    motor_run_i <= 1'h0;
    wait_cyc(4);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[0], 32'h0);
    wr_reg(`SPS_OFF_CTRL, 32'h2);
    wait_cyc(2);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[0], 32'h1);
    $display("Test following error done");
    // Limits in both polarities
    wr_reg(`SPS_OFF_CTRL, 32'h5);
    wait_cyc(4);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[2:1], 32'h1);
    chk32({motion_pos_ok_o, motion_neg_ok_o}, 32'h1);
    chk32(seen[2], 32'h1);
    wr_reg(`SPS_OFF_OUTCFG, 32'h754);
    wr_reg(`SPS_OFF_CTRL, 32'h9);
    wait_cyc(4);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[2:1], 32'h2);
    chk32({motion_pos_ok_o, motion_neg_ok_o}, 32'h2);
    chk32(seen[2], 32'h0);
    wr_reg(`SPS_OFF_CTRL, 32'h1);
    $display("Test limits done");
    // In-position after dwell, boundary of the margin, mode gate
    wr_reg(`SPS_OFF_MARGIN, 32'h28);
    wr_reg(`SPS_OFF_DWELL, 32'h3);
    wr_reg(`SPS_OFF_ACT_POS, 32'h5);
    for (k = 0; k < 100 && seen[1] !== 1'h0; k++) wait_cyc(1);
    chk32(k >= 2 * MS && k <= 4 * MS + 4, 32'h1);
    rd_reg(`SPS_OFF_STATUS);
    chk32(rv[3], 32'h1);
    wr_reg(`SPS_OFF_ACT_POS, 32'h28);
    wait_cyc(3);
    chk32(seen[1], 32'h1);
    wr_reg(`SPS_OFF_DWELL, 32'h0);
    wr_reg(`SPS_OFF_ACT_POS, 32'h5);
    wait_cyc(3);
    chk32(seen[1], 32'h0);
    wr_reg(`SPS_OFF_MODE, 32'h0F);
    wait_cyc(3);
    chk32(seen[1], 32'h1);
    $display("Test in-position done");
    // Power loss while enabled, then enable without power
    chk32(motor_en_o, 32'h1);
    @(posedge mclk_i);
    main_pwr_i <= 1'h0;
    wait_cyc(8);
    chk32({servo_ready_o, rdy_seen}, 32'h0);
    rd_reg(`SPS_OFF_ALARM);
    chk32(rv[2:0] != 3'h0, 32'h1);
    chk32(rv[0], 32'h1);
    // Drop the enable first so no set term survives the clear
    wr_reg(`SPS_OFF_CTRL, 32'h0);
    wr_reg(`SPS_OFF_ALARM, 32'h7);
    rd_reg(`SPS_OFF_ALARM);
    chk32(rv, 32'h0);
    wr_reg(`SPS_OFF_CTRL, 32'h1);
    wait_cyc(4);
    chk32(motor_en_o, 32'h0);
    rd_reg(`SPS_OFF_ALARM);
    chk32(rv[1], 32'h1);
    $display("Test power done");
    print_verdict();
  end
endmodule : sps_status_test
bind sps_status sps_status_chk i_sps_status_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_pwr_i(main_pwr_i),
  .servo_ready_o(servo_ready_o), .motor_en_o(motor_en_o), .motion_pos_ok_o(motion_pos_ok_o),
  .motion_neg_ok_o(motion_neg_ok_o));
